// ---- dv/hamd_host_agent.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Host bus agent: issues one request and collects its decode result.
module hamd_host_agent (
  input  wire         i_mclk,
  input  wire         i_req_ready,
  input  wire         i_dec_valid,
  input  wire         i_claim,
  input  wire         i_smm_hit,
  input  wire         i_gap_hit,
  output logic        o_req_valid,
  output logic [35:0] o_req_addr,
  output logic        o_req_write,
  output logic        o_req_smm,
  output logic [2:0]  o_req_beats
);
  // Idle bus at time zero.
  initial begin
    o_req_valid = 1'b0;
    o_req_addr = 36'h0;
    o_req_write = 1'b0;
    o_req_smm = 1'b0;
    o_req_beats = 3'h1;
  end

  // Holds the request until ready, or for at most eight more cycles; scrambles the address once released.
  task automatic issue(input logic [35:0] a, input logic w, s,
                       input logic [2:0] b, output logic [3:0] r);
    int n;
    n = 0;
    @(posedge i_mclk);
    o_req_valid <= 1'b1;
    o_req_addr <= a;
    o_req_write <= w;
    o_req_smm <= s;
    o_req_beats <= b;
    @(negedge i_mclk);
    while (!i_req_ready && n < 8) begin
      @(negedge i_mclk);
      n++;
    end
    @(posedge i_mclk);
    o_req_valid <= 1'b0;
    o_req_addr <= ~a;
    @(negedge i_mclk);
    r = {i_dec_valid, i_claim, i_smm_hit, i_gap_hit};
  endtask
endmodule // hamd_host_agent

// ---- dv/hamd_top_assertions.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Checks queue limits and decode timing at the top module's ports.
module hamd_top_assertions #(
  parameter ADDR_W = 36
) (
  input wire              i_mclk,
  input wire              i_sys_rst,
  input wire              i_role_mc,
  input wire              i_ioq_deep,
  input wire              i_req_valid,
  input wire [ADDR_W-1:0] i_req_addr,
  input wire [2:0]        i_req_beats,
  input wire              i_ioq_retire,
  input wire              o_req_ready,
  input wire              o_inq_full,
  input wire [2:0]        o_inq_cnt,
  input wire [2:0]        o_obuf_cnt,
  input wire [2:0]        o_ibuf_cnt,
  input wire [2:0]        o_tgt_cnt,
  input wire [3:0]        o_ioq_cnt,
  input wire              o_dec_valid,
  input wire              o_claim,
  input wire              o_no_defer,
  input wire              o_defer_rsp
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // A request is taken when valid meets ready at an edge.
  wire take = i_req_valid && o_req_ready;

  // Taken request into the always-memory low region, then its decode.
  sequence s_take_low;
    take && (i_req_addr[ADDR_W-1:19] == 0);
  endsequence
  sequence s_dec_claim(c);
    o_dec_valid && (o_claim == c);
  endsequence

  a_ioq_limit: assert property (
    o_ioq_cnt >= (i_ioq_deep ? 4'h8 : 4'h1) |-> !o_req_ready)
    else $error("request ready with a full in-order queue");
  a_ioq_count: assert property (
    take && !i_ioq_retire |=> o_ioq_cnt == $past(o_ioq_cnt) + 4'h1)
    else $error("in-order count did not grow on a take");
  a_tgt_cap: assert property (o_tgt_cnt <= 3'h4)
    else $error("target count above four");
  a_inq_full: assert property (
    o_inq_full == (o_inq_cnt == 3'h4) && o_inq_cnt <= 3'h4)
    else $error("inbound queue full flag wrong");
  a_buf_cap: assert property (
    o_obuf_cnt <= 3'h4 && o_ibuf_cnt <= 3'h4)
    else $error("data buffer count above four");
  a_beats_refuse: assert property (
    i_req_valid && (i_req_beats == 3'h0 || i_req_beats > 3'h4)
    |-> !o_req_ready)
    else $error("illegal beat count accepted");
  a_no_defer: assert property (
    !$past(i_sys_rst) |-> !o_defer_rsp && o_no_defer == !i_role_mc)
    else $error("deferral outputs wrong");
  a_dec_timing: assert property (1'b1 |=> o_dec_valid == $past(take))
    else $error("decode pulse not one cycle after take");
  a_low_claim: assert property (
    s_take_low |=> s_dec_claim(i_role_mc))
    else $error("low region claim wrong");
endmodule // hamd_top_assertions

bind hamd_top hamd_top_assertions #(.ADDR_W(ADDR_W)) i_hamd_top_assertions (.*);

// ---- dv/hamd_top_tb.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the address map decoder.
module hamd_top_tb;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_role_mc = 1'b1, hold = 1'b0;
  logic i_compat_strap = 1'b1, i_ioq_deep = 1'b1, i_ioq_retire = 1'b0;
  logic i_tgt_retire = 1'b0, i_obuf_free = 1'b0, i_ibuf_free = 1'b0;
  logic i_inq_push = 1'b0, i_inq_pop = 1'b0, i_attr_we = 1'b0;
  logic i_smm_we = 1'b0, i_dos_hi_pci = 1'b0, i_vga_mem = 1'b0;
  logic i_reclaim_en = 1'b0, i_lgap_en = 1'b0, i_fb_en = 1'b0;
  logic i_mgap_en = 1'b0, i_hgap_en = 1'b0;
  logic [3:0]  i_attr_idx = 4'h0, i_smm_seg = 4'hA, i_ebios_mc = 4'h0, r;
  logic [1:0]  i_attr_val = 2'h0;
  logic [2:0]  i_lgap_size = 3'h2, i_fb_size = 3'h5, i_mgap_size = 3'h1;
  logic [15:0] i_tom_mb = 16'h0040, i_lgap_base_mb = 16'h0010;
  logic [15:0] i_fb_base_mb = 16'h0064, i_mgap_base_mb = 16'h0018;
  logic [15:0] i_hgap_start_mb = 16'h0028, i_hgap_end_mb = 16'h0030;
  wire         i_req_valid, i_req_write, i_req_smm;
  wire  [35:0] i_req_addr;
  wire  [2:0]  i_req_beats, o_tgt_cnt, o_inq_cnt, o_obuf_cnt, o_ibuf_cnt;
  wire         o_req_ready, o_inq_full, o_dec_valid, o_claim, o_smm_hit;
  wire         o_gap_hit, o_no_defer, o_defer_rsp;
  wire  [16:0] o_eff_tom_mb;
  wire  [3:0]  o_ioq_cnt;
  int          mismatches = 0, check_count = 0;

  // Clock and the two parties.
  always #20 i_mclk = ~i_mclk;
  hamd_top i_hamd_top (.*);
  hamd_host_agent i_hamd_host_agent (.i_mclk(i_mclk),
    .i_req_ready(o_req_ready), .i_dec_valid(o_dec_valid),
    .i_claim(o_claim), .i_smm_hit(o_smm_hit), .i_gap_hit(o_gap_hit),
    .o_req_valid(i_req_valid), .o_req_addr(i_req_addr),
    .o_req_write(i_req_write), .o_req_smm(i_req_smm),
    .o_req_beats(i_req_beats));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and access tasks.
  task automatic chk(input logic [16:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rst();
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic attr(input logic [3:0] idx, input logic [1:0] v);
    @(posedge i_mclk);
    i_attr_we <= 1'b1;
    i_attr_idx <= idx;
    i_attr_val <= v;
    @(posedge i_mclk);
    i_attr_we <= 1'b0;
  endtask
  // Full-line request; compares taken and claimed, then retires it unless hold is set.
  task automatic go(input logic [35:0] a, input logic w, s,
                    input logic [1:0] exp);
    i_hamd_host_agent.issue(a, w, s, 3'h4, r);
    chk(r[3:2], exp);
    if (!hold) begin
      @(posedge i_mclk);
      {i_ioq_retire, i_tgt_retire, i_obuf_free, i_ibuf_free} <= 4'hF;
      @(posedge i_mclk);
      {i_ioq_retire, i_tgt_retire, i_obuf_free, i_ibuf_free} <= 4'h0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    rst();
    chk(o_no_defer, 0);
    go(36'h1000, 0, 0, 2'b11);
    go(36'hF8000, 0, 0, 2'b10);
    for (int v = 0; v < 4; v++) begin
      attr(4'hE, v[1:0]);
      go(36'hF8000, 0, 0, {1'b1, v[0]});
      go(36'hF8000, 1, 0, {1'b1, v[1]});
    end
    attr(4'h3, 2'h3);
    go(36'hC4000, 0, 0, 2'b11);
    go(36'hC0000, 0, 0, 2'b10);
    i_ebios_mc <= 4'h2;
    attr(4'hB, 2'h3);
    go(36'hE4000, 0, 0, 2'b11);
    go(36'hE0000, 0, 0, 2'b10);
    attr(4'h0, 2'h3);
    go(36'h80000, 0, 0, 2'b11);
    i_dos_hi_pci <= 1'b1;
    go(36'h80000, 0, 0, 2'b10);
    attr(4'h1, 2'h3);
    i_vga_mem <= 1'b1;
    go(36'hA4000, 0, 0, 2'b11);
    i_vga_mem <= 1'b0;
    go(36'hA4000, 0, 0, 2'b10);
    go(36'hA4000, 0, 1, 2'b11);
    chk(r[1], 1);
    @(posedge i_mclk);
    i_smm_we <= 1'b1;
    i_smm_seg <= 4'hB;
    @(posedge i_mclk);
    i_smm_we <= 1'b0;
    go(36'hA4000, 0, 1, 2'b10);
    go(36'hB4000, 0, 1, 2'b11);
    $display("compatibility test finished");
    // Low gap kept below the memory gap and the high gap.
    {i_reclaim_en, i_lgap_en, i_mgap_en, i_hgap_en} <= 4'hF;
    go(36'h1100000, 0, 0, 2'b10);
    chk(r[0], 1);
    go(36'h1E00000, 0, 0, 2'b11);
    go(36'h2A00000, 0, 0, 2'b10);
    go(36'h3200000, 0, 0, 2'b11);
    go(36'h4600000, 0, 0, 2'b11);
    go(36'h5000000, 0, 0, 2'b10);
    chk(o_eff_tom_mb, 17'h0004E);
    $display("gap test finished");
    i_ioq_deep <= 1'b0;
    hold <= 1'b1;
    go(36'h0, 0, 0, 2'b11);
    go(36'h0, 0, 0, 2'b00);
    @(posedge i_mclk);
    i_ioq_retire <= 1'b1;
    i_ioq_deep <= 1'b1;
    @(posedge i_mclk);
    i_ioq_retire <= 1'b0;
    repeat (3) go(36'h100, 0, 0, 2'b11);
    chk(o_tgt_cnt, 4);
    chk(o_ibuf_cnt, 4);
    go(36'h0, 0, 0, 2'b00);
    i_hamd_host_agent.issue(36'h0, 0, 0, 3'h0, r);
    chk(r, 0);
    i_hamd_host_agent.issue(36'h0, 0, 0, 3'h5, r);
    chk(r, 0);
    @(posedge i_mclk);
    {i_ioq_retire, i_tgt_retire, i_ibuf_free, i_inq_push} <= 4'hF;
    repeat (5) @(posedge i_mclk);
    {i_ioq_retire, i_tgt_retire, i_ibuf_free, i_inq_push} <= 4'h0;
    @(negedge i_mclk);
    chk({o_inq_full, o_inq_cnt, o_tgt_cnt, o_ioq_cnt}, 11'h600);
    @(posedge i_mclk);
    i_inq_pop <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_inq_pop <= 1'b0;
    @(negedge i_mclk);
    chk(o_inq_cnt, 0);
    hold <= 1'b0;
    $display("queue test finished");
    // The role is static, so it only changes while reset is held.
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    i_role_mc <= 1'b0;
    i_fb_en <= 1'b1;
    rst();
    chk(o_no_defer, 1);
    go(36'hF8000, 0, 0, 2'b11);
    go(36'h8300000, 0, 0, 2'b11);
    go(36'h8400000, 0, 0, 2'b10);
    go(36'h1900000, 0, 0, 2'b11);
    i_compat_strap <= 1'b0;
    rst();
    go(36'hF8000, 0, 0, 2'b10);
    hold <= 1'b1;
    go(36'h1900000, 1, 0, 2'b11);
    chk(o_obuf_cnt, 1);
    $display("bridge test finished");
    close_out();
  end

  // Watchdog cuts a hung run short.
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule // hamd_top_tb

// ---- rtl/hamd_attr_chk.v ----
`timescale 1ns/10ps
`include "hamd_consts.vh"

// Checks whether an access direction is allowed by a region attribute.
module hamd_attr_chk (
  input  wire [1:0] i_attr,
  input  wire       i_write,
  output wire       o_ok
);

  // Read needs RO or RW, write needs WO or RW; disabled allows nothing.
  assign o_ok = i_write ? (i_attr == `HAMD_ATTR_WO || i_attr == `HAMD_ATTR_RW)
                        : (i_attr == `HAMD_ATTR_RO || i_attr == `HAMD_ATTR_RW);

endmodule // hamd_attr_chk

// ---- rtl/hamd_gap_hit.v ----
`timescale 1ns/10ps
`include "hamd_consts.vh"

// Power-of-two sized gap window on megabyte units.
module hamd_gap_hit #(
  parameter MB_W = 16
) (
  input  wire [MB_W-1:0] i_addr_mb,
  input  wire [MB_W-1:0] i_base_mb,
  input  wire [2:0]      i_size_code,
  input  wire            i_en,
  output wire            o_hit,
  output wire [MB_W:0]   o_size_mb
);

  wire [MB_W:0] base_x;
  wire [MB_W:0] addr_x;
  wire [MB_W:0] size_x;

  // Codes above five are clamped to 32 Mbytes.
  assign size_x    = {{MB_W{1'b0}}, 1'b1} <<
                     ((i_size_code > `HAMD_GAP_CODE_MAX) ?
                      `HAMD_GAP_CODE_MAX : i_size_code);
  assign base_x    = {1'b0, i_base_mb};
  assign addr_x    = {1'b0, i_addr_mb};
  assign o_size_mb = i_en ? size_x : {(MB_W+1){1'b0}};
  assign o_hit     = i_en && (addr_x >= base_x) && (addr_x < base_x + size_x);

endmodule // hamd_gap_hit

// ---- rtl/hamd_top.v ----
`timescale 1ns/10ps
`include "hamd_consts.vh"

// Notes on behaviour
// - In-order queue depth selectable as one or eight transactions.
// - Bridge takes at most four transactions aimed at its PCI bus.
// - Inbound queue for PCI-initiated host requests is four deep.
// - Memory controller takes at most four transactions to its memory.
// - Four 32-byte outbound and four 32-byte inbound data buffers.
// - Largest transfer is four 64-bit beats, one 32-byte line.
// - Never defer own requests; bridge forbids deferral of its own.
// - Each sub-megabyte region above the lowest 512 Kbytes has disabled, RW, WO or RO attribute.
// - Lowest 512 Kbytes always belong to the memory controller.
// - 80000h-9FFFFh goes to host memory or, if enabled, to PCI.
// - Graphics range goes to PCI unless programmed as memory.
// - SMM space defaults to A0000h-AFFFFh and is relocatable.
// - ISA expansion area is eight 16 Kbyte blocks, own attributes.
// - Extended BIOS is four 16 Kbyte blocks, routed to MC or PCI.
// - Top BIOS block: compatibility bridge RW after reset, others off.
// - Reclaim raises effective top of memory by hidden gap sizes.
// - Low gap: MC only, megabyte aligned, 1-32 Mbytes, goes to PCI.
// - Frame buffer: bridge only, megabyte aligned, 1-32 Mbytes.
// - Memory gap in both agents, above 1 Mbyte, 1-32 Mbytes.
// - High gap has megabyte start and end, up to 64 Gbytes.
// - High gap splits controller memory into a lower and upper range.
module hamd_top #(
  parameter ADDR_W = 36,
  parameter MB_W   = 16
) (
  input  wire              i_mclk,
  input  wire              i_sys_rst,
  input  wire              i_role_mc,
  input  wire              i_compat_strap,
  input  wire              i_ioq_deep,
  input  wire              i_req_valid,
  input  wire [ADDR_W-1:0] i_req_addr,
  input  wire              i_req_write,
  input  wire              i_req_smm,
  input  wire [2:0]        i_req_beats,
  output wire              o_req_ready,
  input  wire              i_ioq_retire,
  input  wire              i_tgt_retire,
  input  wire              i_obuf_free,
  input  wire              i_ibuf_free,
  input  wire              i_inq_push,
  input  wire              i_inq_pop,
  output wire              o_inq_full,
  input  wire              i_attr_we,
  input  wire [3:0]        i_attr_idx,
  input  wire [1:0]        i_attr_val,
  input  wire              i_smm_we,
  input  wire [3:0]        i_smm_seg,
  input  wire              i_dos_hi_pci,
  input  wire              i_vga_mem,
  input  wire [3:0]        i_ebios_mc,
  input  wire [MB_W-1:0]   i_tom_mb,
  input  wire              i_reclaim_en,
  input  wire              i_lgap_en,
  input  wire [MB_W-1:0]   i_lgap_base_mb,
  input  wire [2:0]        i_lgap_size,
  input  wire              i_fb_en,
  input  wire [MB_W-1:0]   i_fb_base_mb,
  input  wire [2:0]        i_fb_size,
  input  wire              i_mgap_en,
  input  wire [MB_W-1:0]   i_mgap_base_mb,
  input  wire [2:0]        i_mgap_size,
  input  wire              i_hgap_en,
  input  wire [MB_W-1:0]   i_hgap_start_mb,
  input  wire [MB_W-1:0]   i_hgap_end_mb,
  output reg               o_dec_valid,
  output reg               o_claim,
  output reg               o_smm_hit,
  output reg               o_gap_hit,
  output reg               o_no_defer,
  output reg               o_defer_rsp,
  output reg  [MB_W:0]     o_eff_tom_mb,
  output reg  [3:0]        o_ioq_cnt,
  output reg  [2:0]        o_tgt_cnt,
  output reg  [2:0]        o_inq_cnt,
  output reg  [2:0]        o_obuf_cnt,
  output reg  [2:0]        o_ibuf_cnt
);

  ////////////////////////////////////////////////////////////////////////////
  // Compatibility-area attribute store.

  reg  [1:0] attr_reg [0:`HAMD_RGN_NUM-1];
  reg  [3:0] smm_seg_reg;
  wire [1:0] bios_rst;

  // The top BIOS block opens only in the compatibility bridge after reset.
  assign bios_rst = (!i_role_mc && i_compat_strap) ?
                    `HAMD_ATTR_RW : `HAMD_ATTR_DIS;

  genvar g;
  generate
    for (g = 0; g < `HAMD_RGN_NUM; g = g + 1) begin : g_attr
      // One attribute per region, written by index.
      always @(posedge i_mclk) begin
        if (i_sys_rst) begin
          attr_reg[g] <= (g == `HAMD_RGN_BIOS) ? bios_rst
                                               : `HAMD_ATTR_DIS;
        end else if (i_attr_we && i_attr_idx == g) begin
          attr_reg[g] <= i_attr_val;
        end
      end
    end
  endgenerate

  // SMM segment, relocatable from its A0000h default.
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      smm_seg_reg <= `HAMD_SMM_SEG_RST;
    end else if (i_smm_we) begin
      smm_seg_reg <= i_smm_seg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode of the request on the port.

  wire [MB_W-1:0] addr_mb;
  wire [5:0]      blk;
  wire            in_first_mb;
  reg  [3:0]      rgn_idx;
  reg             rgn_route_ok;
  reg             rgn_valid;
  wire            attr_ok;
  wire            smm_hit;

  assign addr_mb     = i_req_addr[ADDR_W-1:20];
  assign blk         = i_req_addr[19:14];
  assign in_first_mb = (addr_mb == {MB_W{1'b0}});
  assign smm_hit     = i_req_smm && in_first_mb &&
                       (i_req_addr[19:16] == smm_seg_reg);

  // Region index and routing for the first megabyte.
  always @* begin
    rgn_idx      = `HAMD_RGN_BIOS;
    rgn_route_ok = 1'b0;
    rgn_valid    = 1'b1;
    if (blk < `HAMD_BLK_DOS_HI) begin
      rgn_valid    = 1'b0;
      rgn_route_ok = i_role_mc;
    end else if (blk < `HAMD_BLK_VGA) begin
      rgn_idx      = `HAMD_RGN_DOS_HI;
      rgn_route_ok = i_role_mc ^ i_dos_hi_pci;
    end else if (blk < `HAMD_BLK_ISA) begin
      rgn_idx      = `HAMD_RGN_VGA;
      rgn_route_ok = i_role_mc ~^ i_vga_mem;
    end else if (blk < `HAMD_BLK_EBIOS) begin
      rgn_idx      = `HAMD_RGN_ISA0 + {1'b0, blk[2:0]};
      rgn_route_ok = 1'b1;
    end else if (blk < `HAMD_BLK_BIOS) begin
      rgn_idx      = `HAMD_RGN_EBIOS0 + {2'h0, blk[1:0]};
      rgn_route_ok = i_role_mc ~^ i_ebios_mc[blk[1:0]];
    end else begin
      rgn_idx      = `HAMD_RGN_BIOS;
      rgn_route_ok = 1'b1;
    end
  end

  hamd_attr_chk u_attr_chk (
    .i_attr  (attr_reg[rgn_idx]),
    .i_write (i_req_write),
    .o_ok    (attr_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gap ranges above the first megabyte.

  wire            lgap_hit;
  wire            fb_hit;
  wire            mgap_hit;
  wire            hgap_hit;
  wire [MB_W:0]   lgap_sz;
  wire [MB_W:0]   mgap_sz;
  wire [MB_W:0]   hgap_sz;
  wire            mgap_on;

  // The memory gap must start above the first megabyte.
  assign mgap_on = i_mgap_en && (i_mgap_base_mb != {MB_W{1'b0}});

  hamd_gap_hit #(.MB_W(MB_W)) u_lgap (
    .i_addr_mb   (addr_mb),
    .i_base_mb   (i_lgap_base_mb),
    .i_size_code (i_lgap_size),
    .i_en        (i_lgap_en && i_role_mc),
    .o_hit       (lgap_hit),
    .o_size_mb   (lgap_sz)
  );

  hamd_gap_hit #(.MB_W(MB_W)) u_fb (
    .i_addr_mb   (addr_mb),
    .i_base_mb   (i_fb_base_mb),
    .i_size_code (i_fb_size),
    .i_en        (i_fb_en && !i_role_mc),
    .o_hit       (fb_hit),
    .o_size_mb   ()
  );

  hamd_gap_hit #(.MB_W(MB_W)) u_mgap (
    .i_addr_mb   (addr_mb),
    .i_base_mb   (i_mgap_base_mb),
    .i_size_code (i_mgap_size),
    .i_en        (mgap_on),
    .o_hit       (mgap_hit),
    .o_size_mb   (mgap_sz)
  );

  // High gap spans start up to but not including end.
  assign hgap_hit = i_hgap_en && (addr_mb >= i_hgap_start_mb) &&
                    (addr_mb < i_hgap_end_mb);
  assign hgap_sz  = (i_hgap_en && i_hgap_end_mb > i_hgap_start_mb) ?
                    ({1'b0, i_hgap_end_mb} - {1'b0, i_hgap_start_mb})
                    : {(MB_W+1){1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // Effective top of memory with reclaiming.

  reg  [MB_W+2:0] eff_tom_next;

  // Hidden memory under enabled gaps is moved above the old top.
  always @* begin
    eff_tom_next = {3'h0, i_tom_mb};
    if (i_reclaim_en && i_role_mc) begin
      eff_tom_next = {3'h0, i_tom_mb} + {2'h0, lgap_sz} +
                     {2'h0, mgap_sz} + {2'h0, hgap_sz};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Claim decision.

  wire ext_gap;
  wire mem_hit;
  reg  claim;

  assign ext_gap = lgap_hit || mgap_hit || hgap_hit || fb_hit;
  // Below the effective top, memory is contiguous except inside the gaps,
  // so the high gap's start closes the lower range and its end opens the
  // upper one.
  assign mem_hit = ({3'h0, addr_mb} < eff_tom_next) && !ext_gap;

  // Memory controller owns memory, bridge owns its gap windows.
  always @* begin
    claim = 1'b0;
    if (smm_hit) begin
      claim = i_role_mc;
    end else if (in_first_mb) begin
      if (!rgn_valid) begin
        claim = rgn_route_ok;
      end else begin
        claim = rgn_route_ok && attr_ok;
      end
    end else if (i_role_mc) begin
      claim = mem_hit;
    end else begin
      claim = fb_hit || mgap_hit || hgap_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance limits.

  wire [3:0] ioq_lim;
  wire       ioq_room;
  wire       tgt_room;
  wire       buf_room;
  wire       beats_ok;
  wire       take;
  wire       take_own;

  assign ioq_lim  = i_ioq_deep ? `HAMD_IOQ_DEEP : `HAMD_IOQ_SHALLOW;
  assign ioq_room = (o_ioq_cnt < ioq_lim);
  assign tgt_room = (o_tgt_cnt < `HAMD_TGT_DEPTH);
  assign buf_room = i_req_write ? (o_obuf_cnt < `HAMD_BUF_DEPTH)
                                : (o_ibuf_cnt < `HAMD_BUF_DEPTH);
  assign beats_ok = (i_req_beats != 3'h0) &&
                    (i_req_beats <= `HAMD_MAX_BEATS);
  assign o_req_ready = ioq_room && beats_ok &&
                       (!claim || (tgt_room && buf_room));
  assign take     = i_req_valid && o_req_ready;
  assign take_own = take && claim;
  assign o_inq_full = (o_inq_cnt == `HAMD_INQ_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Occupancy counters.

  wire inq_in;
  wire inq_out;
  wire ob_in;
  wire ib_in;
  wire ob_out;
  wire ib_out;

  assign inq_in  = i_inq_push && !o_inq_full;
  assign inq_out = i_inq_pop && (o_inq_cnt != 3'h0);
  assign ob_in   = take_own && i_req_write;
  assign ib_in   = take_own && !i_req_write;
  assign ob_out  = i_obuf_free && (o_obuf_cnt != 3'h0);
  assign ib_out  = i_ibuf_free && (o_ibuf_cnt != 3'h0);

  // Counters add what was taken and subtract what was retired.
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ioq_cnt  <= 4'h0;
      o_tgt_cnt  <= 3'h0;
      o_inq_cnt  <= 3'h0;
      o_obuf_cnt <= 3'h0;
      o_ibuf_cnt <= 3'h0;
    end else begin
      o_ioq_cnt  <= o_ioq_cnt + {3'h0, take} -
                    {3'h0, i_ioq_retire && (o_ioq_cnt != 4'h0)};
      o_tgt_cnt  <= o_tgt_cnt + {2'h0, take_own} -
                    {2'h0, i_tgt_retire && (o_tgt_cnt != 3'h0)};
      o_inq_cnt  <= o_inq_cnt + {2'h0, inq_in} - {2'h0, inq_out};
      o_obuf_cnt <= o_obuf_cnt + {2'h0, ob_in} - {2'h0, ob_out};
      o_ibuf_cnt <= o_ibuf_cnt + {2'h0, ib_in} - {2'h0, ib_out};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decode result.

  // One-cycle result of each taken request.
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_dec_valid  <= 1'b0;
      o_claim      <= 1'b0;
      o_smm_hit    <= 1'b0;
      o_gap_hit    <= 1'b0;
      o_no_defer   <= 1'b0;
      o_defer_rsp  <= 1'b0;
      o_eff_tom_mb <= {(MB_W+1){1'b0}};
    end else begin
      o_dec_valid  <= take;
      o_claim      <= take_own;
      o_smm_hit    <= take && smm_hit;
      o_gap_hit    <= take && ext_gap && !in_first_mb;
      o_no_defer   <= !i_role_mc;
      o_defer_rsp  <= 1'b0;
      o_eff_tom_mb <= eff_tom_next[MB_W:0];
    end
  end

endmodule // hamd_top

// ---- shared/hamd_consts.vh ----
`ifndef HAMD_CONSTS_VH
`define HAMD_CONSTS_VH

// Access attribute encodings for compatibility-area regions.
`define HAMD_ATTR_DIS      2'h0
`define HAMD_ATTR_RO       2'h1
`define HAMD_ATTR_WO       2'h2
`define HAMD_ATTR_RW       2'h3

// Compatibility region indices.
`define HAMD_RGN_DOS_HI    4'h0
`define HAMD_RGN_VGA       4'h1
`define HAMD_RGN_ISA0      4'h2
`define HAMD_RGN_EBIOS0    4'hA
`define HAMD_RGN_BIOS      4'hE
`define HAMD_RGN_NUM       15

// 16 Kbyte block numbers inside the first megabyte.
`define HAMD_BLK_DOS_HI    6'h20
`define HAMD_BLK_VGA       6'h28
`define HAMD_BLK_ISA       6'h30
`define HAMD_BLK_EBIOS     6'h38
`define HAMD_BLK_BIOS      6'h3C

// Default system-management segment (64 Kbyte unit number A).
`define HAMD_SMM_SEG_RST   4'hA

// Queue and buffer depths.
`define HAMD_IOQ_DEEP      4'h8
`define HAMD_IOQ_SHALLOW   4'h1
`define HAMD_TGT_DEPTH     3'h4
`define HAMD_INQ_DEPTH     3'h4
`define HAMD_BUF_DEPTH     3'h4

// Transfer limits: four 64-bit beats make one 32-byte line.
`define HAMD_MAX_BEATS     3'h4
`define HAMD_LINE_BYTES    32
`define HAMD_BEAT_BYTES    8

// Largest gap size code: 1 Mbyte shifted left by five is 32 Mbytes.
`define HAMD_GAP_CODE_MAX  3'h5

`endif
